// >>> src/crbc_map.vh
`ifndef CRBC_MAP_VH
`define CRBC_MAP_VH
`define CRBC_ROLE_STD 8'h00
`define CRBC_ROLE_ACTIVE 8'h01
`define CRBC_ROLE_STBY1 8'h02
`define CRBC_ROLE_STBY3 8'h04
`define CRBC_ROLE_ALWAYS 8'h05
`define CRBC_CLK_MHZ 100
`define CRBC_FAULT_DLY_US 10
`define CRBC_TURNON_DLY_US 100
`define CRBC_WAKE_MS 3
`define CRBC_SLEEP_MS 5
`define CRBC_WAKE_CYC (`CRBC_WAKE_MS * 1000 * `CRBC_CLK_MHZ - 1)
`define CRBC_SLEEP_CYC (`CRBC_SLEEP_MS * 1000 * `CRBC_CLK_MHZ - 1)
`define CRBC_FAULT_CYC (`CRBC_FAULT_DLY_US * `CRBC_CLK_MHZ)
`define CRBC_TURNON_CYC (`CRBC_TURNON_DLY_US * `CRBC_CLK_MHZ)
`endif

// >>> src/crbc_sync.v
`timescale 1ns/10ps
module crbc_sync
(
  input wire i_clk,
  input wire i_rst_n,
  input wire [4:0] i_async,
  output reg [4:0] o_sync
);
  reg [4:0] meta_r;
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= 5'h00;
      o_sync <= 5'h00;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // crbc_sync

// >>> src/crbc_top.v
// Operation
// - The supply drives the shared wake/fault line as a three-state output announcing faults.
// - Healthy always-on drives high, healthy standby roles float the line, any faulted supply drives low.
// - With the line held high a standby-role supply may sleep when load is light.
// - With the line floating every standby-role supply is forced on.
// - Own fault pulls the line low within 10 us and a low line wakes standby supplies within 100 us.
// - A standby supply wakes within 3 ms after the share level rises across its wake threshold; the code counts the full 3 ms after the sync flops.
// - An active standby supply sleeps within 5 ms after the share level falls below its sleep threshold; the code counts the full 5 ms after the sync flops.
// - Standby on/off decisions use only this supply's own share sensing.
// - After waking, the comparison switches to the lower disable threshold for hysteresis.
// - Role codes are 00h standard, 01h always-on, 02h-04h standby one to three, 05h always standby.
// - Standby-role supplies revert their role to standard redundancy whenever the line is pulled low.
// - Cold standby only while power is requested, standby permit is deasserted and role is 02h-04h; a sleeping supply set to 05h stays asleep.
`timescale 1ns/10ps
`include "crbc_map.vh"
module crbc_top
(
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_role,
  input wire i_role_wr,
  input wire i_fault,
  input wire i_power_on_request_n,
  input wire i_standby_permit_n,
  input wire i_share_above_en,
  input wire i_share_above_dis,
  input wire i_line_in,
  input wire i_line_pulled,
  output reg o_line_out,
  output reg o_line_oe,
  output reg o_converter_on,
  output reg [7:0] o_role,
  output reg o_power_good_out
);
  parameter WAKE_CYC = `CRBC_WAKE_CYC;
  parameter SLEEP_CYC = `CRBC_SLEEP_CYC;
  localparam ST_ON = 1'b0;
  localparam ST_SLEEP = 1'b1;
  reg rst_meta_r;
  reg rst_n_r;
  wire [4:0] sync_w;
  reg [7:0] role_r;
  reg [7:0] role_nxt;
  reg state_r;
  reg state_nxt;
  reg [19:0] cnt_r;
  reg [19:0] cnt_nxt;
  wire line_low;
  wire line_high;
  wire line_float;
  wire power_on_request_n;
  wire permit;
  wire en_cmp;
  wire dis_cmp;
  wire sleep_ok_w;
  wire wake_ok_w;
  wire drive_en_w;
  wire drive_high_w;

  function is_numbered;
    input [7:0] r;
    begin
      is_numbered = (r >= `CRBC_ROLE_STBY1) && (r <= `CRBC_ROLE_STBY3);
    end
  endfunction

  function is_standby;
    input [7:0] r;
    begin
      is_standby = is_numbered(r) || (r == `CRBC_ROLE_ALWAYS);
    end
  endfunction

  function is_active;
    input [7:0] r;
    begin
      is_active = (r == `CRBC_ROLE_ACTIVE);
    end
  endfunction

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pins from the shared line and share comparators pass two flops before use.
  crbc_sync u_sync
  (
    .i_clk(i_clk),
    .i_rst_n(rst_n_r),
    .i_async({i_share_above_dis, i_share_above_en, i_line_pulled, i_line_in, ~i_power_on_request_n}),
    .o_sync(sync_w)
  );

  assign power_on_request_n = sync_w[0];
  // Low is read only when the line is low and some driver pulls it; a floating line has no driver pull and is read as float, not low.
  assign line_low = ~sync_w[1] & sync_w[2];
  assign line_high = sync_w[1];
  assign line_float = ~sync_w[1] & ~sync_w[2];
  assign en_cmp = sync_w[3];
  assign dis_cmp = sync_w[4];
  // The permit input is a configuration strap from local logic, so it is used directly.
  assign permit = ~i_standby_permit_n;
  // Sleep needs line high, power requested, no permit, numbered role and share below disable level.
  assign sleep_ok_w = line_high && power_on_request_n && !permit && is_numbered(role_r) && !dis_cmp && !i_fault;
  // Always standby ignores the share level, so only numbered roles wake on load.
  assign wake_ok_w = en_cmp && (role_r != `CRBC_ROLE_ALWAYS);
  // A fault always wins, so even a standby supply can pull the line low to wake the others.
  assign drive_en_w = i_fault || is_active(role_nxt);
  assign drive_high_w = !i_fault && is_active(role_nxt);

  always @*
  begin
    role_nxt = role_r;
    if (i_role_wr && (i_role <= `CRBC_ROLE_ALWAYS))
      role_nxt = i_role;
    // Checking the next role means a standby write during a low line never shows for a cycle.
    if (line_low && is_standby(role_nxt))
      role_nxt = `CRBC_ROLE_STD;
  end

  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = 20'h00000;
    case (state_r)
      ST_ON:
      begin
        if (sleep_ok_w)
        begin
          if (cnt_r >= SLEEP_CYC[19:0])
            state_nxt = ST_SLEEP;
          else
            cnt_nxt = cnt_r + 20'h00001;
        end
      end
      ST_SLEEP:
      begin
        if (line_float || line_low || !is_standby(role_r) || !power_on_request_n || permit)
          state_nxt = ST_ON;
        else if (wake_ok_w)
        begin
          // The count runs WAKE_CYC+1 cycles of wake_ok_w, the whole 3 ms limit, on top of the sync delay.
          if (cnt_r >= WAKE_CYC[19:0])
            state_nxt = ST_ON;
          else
            cnt_nxt = cnt_r + 20'h00001;
        end
      end
      default:
        state_nxt = ST_ON;
    endcase
  end

  always @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      role_r <= `CRBC_ROLE_STD;
      state_r <= ST_ON;
      cnt_r <= 20'h00000;
    end
    else
    begin
      role_r <= role_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // The role output mirrors the next role, so a write shows on the same edge that loads role_r.
  always @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_role <= `CRBC_ROLE_STD;
    end
    else
    begin
      o_role <= role_nxt;
    end
  end

  // Fault is a same-clock input, so the line goes low one edge later, far inside 10 us.
  // The enable stays low in reset so a supply coming up never fights the shared line.
  always @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_line_out <= 1'b0;
      o_line_oe <= 1'b0;
    end
    else
    begin
      o_line_out <= drive_high_w;
      o_line_oe <= drive_en_w;
    end
  end

  // The converter defaults on in reset; the sleep path, a missing power request or a fault turns it off.
  always @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_converter_on <= 1'b1;
      o_power_good_out <= 1'b0;
    end
    else
    begin
      o_converter_on <= (state_nxt == ST_ON) && power_on_request_n && !i_fault;
      o_power_good_out <= power_on_request_n && !i_fault;
    end
  end
endmodule // crbc_top

// >>> sim/crbc_props.sv
`timescale 1ns/10ps
module crbc_props
#(
  parameter WAKE_CYC = 7,
  parameter SLEEP_CYC = 9
)
(
  input wire i_clk, i_rst_n, i_role_wr, i_fault, i_power_on_request_n, i_standby_permit_n,
  input wire i_share_above_en, i_share_above_dis, i_line_in, i_line_pulled,
  input wire o_line_out, o_line_oe, o_converter_on, o_power_good_out,
  input wire [7:0] i_role, o_role
);
  // Two sync stages plus the WAKE_CYC+1 count length add three cycles to the wake count; the output register, fed from state_nxt, adds none.
  int en_cnt;
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      en_cnt <= 0;
    else
      en_cnt <= (i_share_above_en && !i_fault && !i_power_on_request_n) ? en_cnt + 1 : 0;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence line_high_s;
    i_line_in[*3];
  endsequence
  AST_FAULT_LOW: assert property (i_fault[*4] |-> o_line_oe && !o_line_out)
    else $error("no low drive");
  AST_ACTIVE_HIGH: assert property ((o_role == 8'h01 && !i_fault)[*2] |-> o_line_oe && o_line_out)
    else $error("no high drive");
  AST_STBY_FLOAT: assert property ((o_role != 8'h01 && !i_fault)[*2] |-> !o_line_oe)
    else $error("line driven");
  AST_ROLE_LOAD: assert property (line_high_s ##0 (i_role_wr && i_role <= 8'h05) |=> o_role == $past(i_role))
    else $error("role lost");
  AST_ROLE_KEEP: assert property (line_high_s ##0 (i_role_wr && i_role > 8'h05) |=> $stable(o_role))
    else $error("bad role taken");
  AST_REVERT: assert property ((!i_line_in && i_line_pulled)[*4] |-> o_role < 8'h02 || o_role > 8'h05)
    else $error("role kept");
  AST_FORCE_ON: assert property ((!i_line_in && !o_line_oe && !i_fault && !i_power_on_request_n)[*4] |-> o_converter_on)
    else $error("not woken");
  AST_WAKE: assert property (en_cnt > WAKE_CYC + 4 |-> o_converter_on)
    else $error("late wake");
  AST_PGOOD_ON: assert property ((!i_power_on_request_n && !i_fault)[*4] |-> o_power_good_out)
    else $error("power good missing");
  AST_PGOOD_FAULT: assert property (i_fault[*2] |-> !o_power_good_out)
    else $error("power good in fault");
endmodule // crbc_props
bind crbc_top crbc_props #(.WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC)) i_props (.*);

// >>> sim/crbc_line_model.sv
`timescale 1ns/10ps
module crbc_line_model
(
  input wire i_oe,
  input wire i_out,
  input wire i_hi,
  input wire i_lo,
  output wire o_level,
  output wire o_pulled
);
  // A faulted supply wins over a high driver, and the weak pull-down sets an undriven line.
  assign o_pulled = i_oe | i_hi | i_lo;
  assign o_level = !(i_lo || (i_oe && !i_out)) && (i_hi || i_oe);
endmodule // crbc_line_model

// >>> sim/crbc_top_tb.sv
`timescale 1ns/10ps
module crbc_top_tb;
  reg i_clk = 0, i_rst_n = 0, i_role_wr = 0, i_fault = 0, i_share_above_en = 0, i_share_above_dis = 0;
  reg i_power_on_request_n = 1, i_standby_permit_n = 0, hi = 1, lo = 0;
  reg [7:0] i_role = 8'h00;
  wire i_line_in, i_line_pulled, o_line_out, o_line_oe, o_converter_on, o_power_good_out;
  wire [7:0] o_role;
  wire [10:0] got = {o_role, o_converter_on, o_line_oe, o_line_out & o_line_oe};
  int num_errors = 0, samples_checked = 0, k;
  logic [10:0] exp_q[$];
  always #5 i_clk = ~i_clk;
  crbc_top #(.WAKE_CYC(7), .SLEEP_CYC(9)) i_dut (.*);
  crbc_line_model i_far (.i_oe(o_line_oe), .i_out(o_line_out), .i_hi(hi), .i_lo(lo),
    .o_level(i_line_in), .o_pulled(i_line_pulled));
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task wr(input logic [7:0] r);
    i_role = r;
    i_role_wr = 1;
    step(1);
    i_role_wr = 0;
    step(1);
  endtask
  task go(input int n, input logic [7:0] r, input logic c, input logic [1:0] l);
    step(n);
    exp_q.push_back({r, c, l});
  endtask
  task compare_state(input logic [10:0] want);
    samples_checked++;
    if (got !== want)
    begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, got, want);
    end
  endtask
  always @(negedge i_clk)
    if (exp_q.size() > 0)
      compare_state(exp_q.pop_front());
  initial
  begin
    k = $urandom(32'h590f4eb6);
    step(4);
    i_rst_n = 1;
    step(3);
    for (int r = 0; r < 10; r++)
    begin
      wr(8'(r < 6 ? r : 6 + $urandom % 250));
      go(0, 8'(r < 6 ? r : 5), 0, {r == 1, r == 1});
    end
    i_power_on_request_n = 0;
    wr(8'h02);
    go(16, 8'h02, 1, 0);
    i_standby_permit_n = 1;
    go(16, 8'h02, 0, 0);
    i_share_above_en = 1;
    i_share_above_dis = 1;
    go(14, 8'h02, 1, 0);
    i_share_above_en = 0;
    go(16, 8'h02, 1, 0);
    i_share_above_dis = 0;
    go(16, 8'h02, 0, 0);
    hi = 0;
    go(5, 8'h02, 1, 0);
    hi = 1;
    go(16, 8'h02, 0, 0);
    lo = 1;
    go(6, 8'h00, 1, 0);
    lo = 0;
    i_power_on_request_n = 1;
    wr(8'h03);
    i_fault = 1;
    go(6, 8'h00, 0, 2);
    step(1);
    end_of_test;
  end
endmodule // crbc_top_tb
